// >>> clock_source_model.sv
// Behavioural clock source: sync reference pulses and clock presence.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
    // Sample clock
    input wire logic clock,
    // Pins toward the block
    output logic sysref_level,
    output logic clock_present
);
    initial
    begin
        sysref_level = 1'b0;
        clock_present = 1'b1;
    end
    // Levels stand whole cycles so each transition meets the window
    task automatic pulse(input int high, input int low);
        sysref_level <= 1'b1;
        repeat (high) @(posedge clock);
        sysref_level <= 1'b0;
        repeat (low) @(posedge clock);
    endtask : pulse
    task automatic set_present(input logic v);
        clock_present <= v;
    endtask : set_present
endmodule : clock_source_model
`default_nettype wire

// >>> clock_sysref_pkg.sv
// Constants and types for the sample clock and sync reference control block.
// Assumes one sample-clock domain and a simple byte-wide register port.
package clock_sysref_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int DELAY_W = 7;
    localparam int DELAY_DEPTH = 128;
    localparam int MARGIN_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] CLOCK_DELAY_CONTROL_ADDR = 10'h117;
    localparam logic [ADDR_W-1:0] CLOCK_FINE_SKEW_ADDR = 10'h118;
    localparam logic [ADDR_W-1:0] INPUT_CLOCK_DETECT_STATUS_ADDR = 10'h11C;
    localparam logic [ADDR_W-1:0] SYNC_REF_CAPTURE_CONFIG_ADDR = 10'h120;
    localparam logic [ADDR_W-1:0] SYNC_REF_SKIP_COUNT_ADDR = 10'h121;
    localparam logic [ADDR_W-1:0] SYNC_REF_TIMESTAMP_DELAY_ADDR = 10'h123;
    localparam logic [ADDR_W-1:0] SYNC_REF_CAPTURE_MARGIN_ADDR = 10'h128;

    // Field positions
    localparam int FINE_ENABLE_BIT = 0;
    localparam int CLOCK_DETECT_BIT = 0;
    localparam int FLAG_RESET_BIT = 6;
    localparam int TRANSITION_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int MODE_LSB = 1;
    localparam int SKIP_LSB = 0;
    localparam int SETUP_LSB = 0;
    localparam int HOLD_LSB = 4;

    // Reset values
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // Capture modes; both upper codes select N-shot
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;

    // Fine skew code limits, two's complement; step is about 1.7 ps
    localparam int FINE_STEP_FS = 1700;
    localparam logic signed [DATA_W-1:0] FINE_CODE_MIN = 8'shA8;
    localparam logic signed [DATA_W-1:0] FINE_CODE_MAX = 8'sh57;

    localparam logic [MARGIN_W-1:0] MARGIN_MAX = 4'hF;

    typedef enum logic [1:0] {
        shot_idle,
        shot_skip,
        shot_spent
    } shot_state_type;

endpackage : clock_sysref_pkg

// >>> sample_clock_sysref_control.sv
// Sample clock skew and sync reference capture control, with register port.
// Assumes everything runs on the sample clock; pins are synchronised here.
//
// Notes on behaviour
// - Enabling fine skew applies it, resets datapath.
// - Fine skew code two's complement, saturates -88/+87.
// - Status bit 0 shows input clock detected.
// - Flag reset holds all capture status flags.
// - Transition bit picks rising or falling transition.
// - Edge bit picks rising or falling clock sample.
// - Mode disabled, continuous, N-shot with skip count.
// - Timestamp delay 0..127 clocks, ignored in normal mode.
// - Setup and hold status readable in margin register.
`timescale 1ns/1ps
`default_nettype none
module sample_clock_sysref_control (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register port
    input wire logic [clock_sysref_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [clock_sysref_pkg::DATA_W-1:0] reg_wdata,
    output logic [clock_sysref_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Pins
    input wire logic sysref_level,
    input wire logic clock_present,
    // Chip mode from neighbouring logic
    input wire logic [1:0] chip_sync_mode,
    // Clock path controls
    output logic fine_skew_enable,
    output logic [clock_sysref_pkg::DATA_W-1:0] fine_skew_code,
    output logic datapath_reset,
    // Capture result
    output logic sysref_capture
);
    import clock_sysref_pkg::*;

    typedef struct packed {
        logic [1:0] sysref_sync;
        logic [1:0] detect_sync;
        logic fine_en;
        logic [DATA_W-1:0] fine_raw;
        logic [DATA_W-1:0] fine_out;
        logic flag_reset;
        logic high_to_low;
        logic edge_falling;
        logic [1:0] mode;
        logic [MARGIN_W-1:0] skip_count;
        logic [DELAY_W-1:0] ts_delay;
        shot_state_type shot;
        logic [MARGIN_W-1:0] skipped;
        logic dp_reset;
        logic capture;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic ref_event;
    logic [MARGIN_W-1:0] setup_status;
    logic [MARGIN_W-1:0] hold_status;
    logic accept;
    logic delayed_capture;
    logic [DELAY_W-1:0] effective_delay;

    // Codes past either end saturate; the raw code is kept for read-back
    function automatic logic [DATA_W-1:0] clamp_fine(input logic [DATA_W-1:0] code);
        logic signed [DATA_W-1:0] value;
        value = signed'(code);
        if (value <= FINE_CODE_MIN)
            clamp_fine = FINE_CODE_MIN;
        else if (value >= FINE_CODE_MAX)
            clamp_fine = FINE_CODE_MAX;
        else
            clamp_fine = code;
    endfunction : clamp_fine

    // Both upper mode codes mean N-shot
    function automatic logic is_nshot(input logic [1:0] mode);
        is_nshot = (mode != MODE_DISABLED) && (mode != MODE_CONTINUOUS);
    endfunction : is_nshot

    // Reserved bits read as zero; unmapped offsets return a fixed byte
    function automatic logic [DATA_W-1:0] read_register(
        input logic [ADDR_W-1:0] addr,
        input state_type s,
        input logic [MARGIN_W-1:0] setup,
        input logic [MARGIN_W-1:0] hold
    );
        logic [DATA_W-1:0] value;
        value = UNMAPPED_READ;
        unique case (addr)
            CLOCK_DELAY_CONTROL_ADDR:
            begin
                value = {7'h00, s.fine_en};
            end
            CLOCK_FINE_SKEW_ADDR:
            begin
                // Raw code as written, so software sees what it stored
                value = s.fine_raw;
            end
            INPUT_CLOCK_DETECT_STATUS_ADDR:
            begin
                value = {7'h00, s.detect_sync[1]};
            end
            SYNC_REF_CAPTURE_CONFIG_ADDR:
            begin
                value = {1'b0, s.flag_reset, 1'b0, s.high_to_low,
                         s.edge_falling, s.mode, 1'b0};
            end
            SYNC_REF_SKIP_COUNT_ADDR:
            begin
                value = {4'h0, s.skip_count};
            end
            SYNC_REF_TIMESTAMP_DELAY_ADDR:
            begin
                value = {1'b0, s.ts_delay};
            end
            SYNC_REF_CAPTURE_MARGIN_ADDR:
            begin
                value = {hold, setup};
            end
            default:
            begin
                value = UNMAPPED_READ;
            end
        endcase
        read_register = value;
    endfunction : read_register

    // Sampler sees the synchronised level only
    sysref_sampler u_sampler (
        .clock(clock),
        .arst_n(arst_n),
        .edge_falling(s_q.edge_falling),
        .high_to_low(s_q.high_to_low),
        .flags_hold(s_q.flag_reset),
        .level(s_q.sysref_sync[1]),
        .event_pulse(ref_event),
        .setup_status(setup_status),
        .hold_status(hold_status)
    );

    // Full-depth line, so the longest delay never wraps
    sysref_delay_line #(
        .DEPTH(DELAY_DEPTH)
    ) u_delay (
        .clock(clock),
        .arst_n(arst_n),
        .pulse_in(accept),
        .delay(effective_delay),
        .pulse_out(delayed_capture)
    );

    // Normal sync mode ignores the programmed delay
    assign effective_delay = (chip_sync_mode == 2'h0) ? '0 : s_q.ts_delay;

    always_comb
    begin
        s_d = s_q;
        accept = 1'b0;
        s_d.dp_reset = 1'b0;
        s_d.rvalid = 1'b0;
        // Pin synchronisers: only the second stage feeds logic
        s_d.sysref_sync = {s_q.sysref_sync[0], sysref_level};
        s_d.detect_sync = {s_q.detect_sync[0], clock_present};

        // Capture qualification
        unique case (s_q.mode)
            MODE_DISABLED:
            begin
                accept = 1'b0;
            end
            MODE_CONTINUOUS:
            begin
                accept = ref_event;
            end
            default:
            begin
                // N-shot counts matching events against the skip count, then goes quiet
                unique case (s_q.shot)
                    shot_idle:
                    begin
                        accept = 1'b0;
                    end
                    shot_skip:
                    begin
                        if (ref_event && s_q.skipped == s_q.skip_count)
                        begin
                            accept = 1'b1;
                            s_d.shot = shot_spent;
                        end
                        else if (ref_event)
                        begin
                            s_d.skipped = MARGIN_W'(s_q.skipped + 4'h1);
                        end
                    end
                    shot_spent:
                    begin
                        // Stays here until the next config write, which rearms N-shot or returns to idle
                        accept = 1'b0;
                    end
                    default:
                    begin
                        s_d.shot = shot_idle;
                    end
                endcase
            end
        endcase
        // Capture leaves through a flop so the output never glitches
        s_d.capture = delayed_capture;

        // Register writes; a write to the config rearms N-shot over a same-cycle event
        if (reg_write)
        begin
            unique case (reg_addr)
                CLOCK_DELAY_CONTROL_ADDR:
                begin
                    s_d.fine_en = reg_wdata[FINE_ENABLE_BIT];
                    // Only the 0 to 1 step resets the datapath, not repeated writes
                    s_d.dp_reset = reg_wdata[FINE_ENABLE_BIT] && !s_q.fine_en;
                end
                CLOCK_FINE_SKEW_ADDR:
                begin
                    s_d.fine_raw = reg_wdata;
                end
                SYNC_REF_CAPTURE_CONFIG_ADDR:
                begin
                    s_d.flag_reset = reg_wdata[FLAG_RESET_BIT];
                    s_d.high_to_low = reg_wdata[TRANSITION_BIT];
                    s_d.edge_falling = reg_wdata[EDGE_BIT];
                    s_d.mode = reg_wdata[MODE_LSB +: 2];
                    s_d.skipped = '0;
                    s_d.shot = is_nshot(reg_wdata[MODE_LSB +: 2]) ? shot_skip : shot_idle;
                end
                SYNC_REF_SKIP_COUNT_ADDR:
                begin
                    s_d.skip_count = reg_wdata[SKIP_LSB +: MARGIN_W];
                end
                SYNC_REF_TIMESTAMP_DELAY_ADDR:
                begin
                    s_d.ts_delay = reg_wdata[DELAY_W-1:0];
                end
                default:
                begin
                end
            endcase
        end

        // Saturated skew code goes out only while enabled
        s_d.fine_out = s_q.fine_en ? clamp_fine(s_q.fine_raw) : '0;

        // Register reads, answered one cycle later; rdata holds until the next read
        if (reg_read)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = read_register(reg_addr, s_q, setup_status, hold_status);
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // Reset values come from the package so the map and the flops agree
            s_q.sysref_sync <= '0;
            s_q.detect_sync <= '0;
            s_q.fine_en <= REG_RESET[FINE_ENABLE_BIT];
            s_q.fine_raw <= REG_RESET;
            s_q.fine_out <= REG_RESET;
            s_q.flag_reset <= REG_RESET[FLAG_RESET_BIT];
            s_q.high_to_low <= REG_RESET[TRANSITION_BIT];
            s_q.edge_falling <= REG_RESET[EDGE_BIT];
            s_q.mode <= REG_RESET[MODE_LSB +: 2];
            s_q.skip_count <= REG_RESET[SKIP_LSB +: MARGIN_W];
            s_q.ts_delay <= REG_RESET[DELAY_W-1:0];
            s_q.shot <= shot_idle;
            s_q.skipped <= '0;
            s_q.dp_reset <= 1'b0;
            s_q.capture <= 1'b0;
            s_q.rdata <= REG_RESET;
            s_q.rvalid <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign fine_skew_enable = s_q.fine_en;
    assign fine_skew_code = s_q.fine_out;
    assign datapath_reset = s_q.dp_reset;
    assign sysref_capture = s_q.capture;

endmodule : sample_clock_sysref_control
`default_nettype wire

// >>> sample_clock_sysref_control_asserts.sv
// Assertions on the register port and outputs of the control block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module sample_clock_sysref_control_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register port
    input wire logic [clock_sysref_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [clock_sysref_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [clock_sysref_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    // Outputs
    input wire logic fine_skew_enable,
    input wire logic [clock_sysref_pkg::DATA_W-1:0] fine_skew_code,
    input wire logic datapath_reset,
    input wire logic sysref_capture
);
    import clock_sysref_pkg::*;
    logic fl_q;
    logic held_q;
    logic cfg_wr;
    assign cfg_wr = reg_write && reg_addr == SYNC_REF_CAPTURE_CONFIG_ADDR;
    // Flags count as held only once the reset bit has stood a full cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fl_q <= 1'b0;
            held_q <= 1'b0;
        end
        else
        begin
            if (cfg_wr)
                fl_q <= reg_wdata[FLAG_RESET_BIT];
            held_q <= fl_q && !cfg_wr;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (reg_read |=> reg_rvalid)
        else $error("read not answered");
    a_stray_answer: assert property (!reg_read |=> !reg_rvalid)
        else $error("answer without read");
    a_enable_reset: assert property (reg_write && reg_addr == CLOCK_DELAY_CONTROL_ADDR
        && reg_wdata[0] && !fine_skew_enable |=> datapath_reset && fine_skew_enable)
        else $error("enable did not reset datapath");
    a_reset_single: assert property (datapath_reset |=> !datapath_reset)
        else $error("datapath reset too long");
    a_enable_follows: assert property (reg_write && reg_addr == CLOCK_DELAY_CONTROL_ADDR
        |=> fine_skew_enable == $past(reg_wdata[0]))
        else $error("enable bit not applied");
    a_skew_clamp: assert property ($signed(fine_skew_code) >= FINE_CODE_MIN
        && $signed(fine_skew_code) <= FINE_CODE_MAX)
        else $error("skew code outside range");
    a_capture_pulse: assert property (sysref_capture |=> !sysref_capture)
        else $error("capture longer than a cycle");
    a_detect_layout: assert property (reg_read && reg_addr == INPUT_CLOCK_DETECT_STATUS_ADDR
        |=> reg_rdata[7:1] == 7'h00)
        else $error("status reserved bits set");
    a_flags_held: assert property (reg_read && held_q
        && reg_addr == SYNC_REF_CAPTURE_MARGIN_ADDR |=> reg_rdata == 8'h00)
        else $error("flags not held in reset");
endmodule : sample_clock_sysref_control_asserts
bind sample_clock_sysref_control sample_clock_sysref_control_asserts chk (.clock, .arst_n,
    .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid,
    .fine_skew_enable, .fine_skew_code, .datapath_reset, .sysref_capture);
`default_nettype wire

// >>> sample_clock_sysref_control_tb.sv
// Self-checking bench for the sample clock and sync reference block.
// Assumes the clock source model drives the pins; results meet queued notes.
`timescale 1ns/1ps
`default_nettype none
module sample_clock_sysref_control_tb;
    import clock_sysref_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 10'h000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic [1:0] chip_sync_mode = 2'h0;
    logic [DATA_W-1:0] reg_rdata, fine_skew_code, c, e;
    logic reg_rvalid, fine_skew_enable, datapath_reset;
    logic sysref_capture, sysref_level, clock_present;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 9039;
    logic [DATA_W-1:0] rd_q[$];
    int cap_q[$];
    logic [DATA_W-1:0] codes[8] = '{8'hA8, 8'hA7, 8'h57, 8'h58, 8'h56, 8'h80, 8'h7F, 8'hA9};
    logic [ADDR_W-1:0] ra[6] = '{10'h117, 10'h118, 10'h120, 10'h121, 10'h123, 10'h3FF};
    sample_clock_sysref_control uut (.clock, .arst_n, .reg_addr, .reg_write, .reg_read,
        .reg_wdata, .reg_rdata, .reg_rvalid, .sysref_level, .clock_present, .chip_sync_mode,
        .fine_skew_enable, .fine_skew_code, .datapath_reset, .sysref_capture);
    clock_source_model src (.clock, .sysref_level, .clock_present);
    always #2.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        rd_q.push_back(x);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
    endtask : rd
    // Pulses with index lo..hi are noted as captures, lat cycles late
    task automatic burst(input logic [7:0] cfg, input int lat, input int n, input int lo,
        input int hi);
        int h;
        int l;
        wr(SYNC_REF_CAPTURE_CONFIG_ADDR, cfg);
        for (int i = 0; i < n; i++)
        begin
            h = 2 + ($random(seed) & 3);
            l = 2 + ($random(seed) & 3);
            @(posedge clock);
            if (i >= lo && i <= hi)
                cap_q.push_back(cyc + (cfg[4] ? h : 0) + 5 + lat);
            src.pulse(h, l);
        end
        repeat (150) @(posedge clock);
        $display("test capture %0h done", cfg);
    endtask : burst
    always @(posedge clock)
    begin
        if (reg_rvalid === 1'b1)
            check("rdata", reg_rdata, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
        if (sysref_capture === 1'b1)
            check("capture cycle", cyc, cap_q.size() > 0 ? cap_q.pop_front() : -1);
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], 8'h00);
        wr(INPUT_CLOCK_DETECT_STATUS_ADDR, 8'hFE);
        rd(INPUT_CLOCK_DETECT_STATUS_ADDR, 8'h01);
        $display("test reset done");
        wr(CLOCK_FINE_SKEW_ADDR, 8'hA7);
        wr(CLOCK_DELAY_CONTROL_ADDR, 8'h01);
        @(negedge clock);
        check("dp reset", datapath_reset, 1'b1);
        check("fine enable", fine_skew_enable, 1'b1);
        @(negedge clock);
        check("dp reset", datapath_reset, 1'b0);
        for (int i = 0; i < 12; i++)
        begin
            c = (i < 8) ? codes[i] : 8'($random(seed));
            e = ($signed(c) < -88) ? 8'hA8 : ($signed(c) > 87) ? 8'h57 : c;
            wr(CLOCK_FINE_SKEW_ADDR, c);
            rd(CLOCK_FINE_SKEW_ADDR, c);
            @(negedge clock);
            check("skew code", fine_skew_code, e);
        end
        wr(CLOCK_DELAY_CONTROL_ADDR, 8'h00);
        repeat (2) @(negedge clock);
        check("skew off", {fine_skew_enable, fine_skew_code}, 9'h000);
        $display("test skew done");
        chip_sync_mode <= 2'h1;
        wr(SYNC_REF_TIMESTAMP_DELAY_ADDR, 8'h03);
        for (int k = 0; k < 4; k++)
            burst({3'h0, k[1], k[0], 2'h1, 1'b0}, 3 + k[0], 3, 0, 2);
        wr(SYNC_REF_TIMESTAMP_DELAY_ADDR, 8'h7F);
        burst(8'h02, 127, 2, 0, 1);
        chip_sync_mode <= 2'h0;
        burst(8'h02, 0, 3, 0, 2);
        burst(8'h00, 0, 3, 1, 0);
        wr(SYNC_REF_SKIP_COUNT_ADDR, 8'h02);
        burst(8'h04, 0, 5, 2, 2);
        wr(SYNC_REF_SKIP_COUNT_ADDR, 8'h00);
        burst(8'h06, 0, 3, 0, 0);
        wr(SYNC_REF_CAPTURE_CONFIG_ADDR, 8'h42);
        repeat (3) @(posedge clock);
        rd(SYNC_REF_CAPTURE_MARGIN_ADDR, 8'h00);
        rd(SYNC_REF_CAPTURE_CONFIG_ADDR, 8'h42);
        wr(SYNC_REF_CAPTURE_CONFIG_ADDR, 8'h00);
        src.pulse(3, 20);
        rd(SYNC_REF_CAPTURE_MARGIN_ADDR, 8'h2F);
        src.set_present(1'b0);
        repeat (5) @(posedge clock);
        rd(INPUT_CLOCK_DETECT_STATUS_ADDR, 8'h00);
        repeat (5) @(posedge clock);
        $display("test status done");
        check("pending notes", rd_q.size() + cap_q.size(), 0);
        stop_test();
    end
endmodule : sample_clock_sysref_control_tb
`default_nettype wire

// >>> sysref_delay_line.sv
// Pulse delay line for the captured sync reference timestamp.
// Assumes pulses and delay setting come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sysref_delay_line #(
    parameter int DEPTH = clock_sysref_pkg::DELAY_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pulse path
    input wire logic pulse_in,
    input wire logic [clock_sysref_pkg::DELAY_W-1:0] delay,
    output logic pulse_out
);
    import clock_sysref_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0] taps;
    } line_type;

    line_type s_q;
    line_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.taps = {s_q.taps[DEPTH-2:0], pulse_in};
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Zero delay bypasses the taps; the caller registers the result
    assign pulse_out = (delay == '0) ? pulse_in : s_q.taps[DELAY_W'(delay - 7'h01)];

endmodule : sysref_delay_line
`default_nettype wire

// >>> sysref_sampler.sv
// Transition detector and capture margin monitor for the sync reference.
// Assumes the level input is already synchronised to the sample clock.
`timescale 1ns/1ps
`default_nettype none
module sysref_sampler (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Configuration
    input wire logic edge_falling,
    input wire logic high_to_low,
    input wire logic flags_hold,
    // Sync reference level
    input wire logic level,
    // Results
    output logic event_pulse,
    output logic [clock_sysref_pkg::MARGIN_W-1:0] setup_status,
    output logic [clock_sysref_pkg::MARGIN_W-1:0] hold_status
);
    import clock_sysref_pkg::*;

    typedef struct packed {
        logic staged;
        logic prev;
        logic [MARGIN_W-1:0] steady;
        logic hold_run;
        logic event_seen;
        logic [MARGIN_W-1:0] setup;
        logic [MARGIN_W-1:0] hold;
    } sampler_type;

    sampler_type s_q;
    sampler_type s_d;
    logic sample;
    logic change;
    logic match;

    always_comb
    begin
        s_d = s_q;
        // Falling edge is modelled as a half cycle later, resolved on the next rise
        sample = edge_falling ? s_q.staged : level;
        change = sample != s_q.prev;
        match = change && (sample == !high_to_low);
        s_d.staged = level;
        s_d.prev = sample;
        s_d.event_seen = match;
        if (change)
            s_d.steady = '0;
        else if (s_q.steady != MARGIN_MAX)
            s_d.steady = MARGIN_W'(s_q.steady + 4'h1);
        if (s_q.hold_run)
        begin
            if (change || s_q.hold == MARGIN_MAX)
                s_d.hold_run = 1'b0;
            else
                s_d.hold = MARGIN_W'(s_q.hold + 4'h1);
        end
        if (match)
        begin
            s_d.setup = s_q.steady;
            s_d.hold = '0;
            s_d.hold_run = 1'b1;
        end
        if (flags_hold)
        begin
            s_d.setup = '0;
            s_d.hold = '0;
            s_d.hold_run = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign event_pulse = s_q.event_seen;
    assign setup_status = s_q.setup;
    assign hold_status = s_q.hold;

endmodule : sysref_sampler
`default_nettype wire
